// file: design/tss_pkg.sv
// Package: register map, field positions and reset values of the timer slave-mode block
package tss_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SMC = 8'h04;
  localparam logic [7:0] OFS_CAP = 8'h08;
  localparam logic [7:0] OFS_ARR = 8'h0c;
  localparam logic [7:0] OFS_CMP = 8'h10;
  localparam logic [7:0] OFS_CNT = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_PSC = 8'h1c;
  // Control register fields
  localparam int CTRL_CEN = 0;
  localparam int CTRL_URS = 1;
  localparam int CTRL_XOR = 2;
  localparam int CTRL_TIE = 3;
  localparam int CTRL_MMS = 4;
  // Slave mode register fields
  localparam int SMC_SMS = 0;
  localparam int SMC_TS = 4;
  localparam int SMC_MSM = 7;
  localparam int SMC_ETF = 8;
  localparam int SMC_ETPS = 12;
  localparam int SMC_ETP = 14;
  localparam int SMC_ECE = 15;
  // Capture register fields
  localparam int CAP_CC1S = 0;
  localparam int CAP_CC1P = 2;
  localparam int CAP_IC1F = 4;
  localparam int CAP_CC2S = 8;
  localparam int CAP_CC2P = 10;
  localparam int CAP_IC2F = 12;
  // Status register: trigger flag
  localparam int STAT_TIF = 0;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] SMC_RST = 16'h0000;
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic [15:0] ARR_RST = 16'hffff;
  // Slave mode codes
  localparam logic [2:0] SMS_OFF = 3'h0;
  localparam logic [2:0] SMS_RESET = 3'h4;
  localparam logic [2:0] SMS_GATED = 3'h5;
  localparam logic [2:0] SMS_TRIG = 3'h6;
  localparam logic [2:0] SMS_EXT1 = 3'h7;
  // Trigger source codes
  localparam logic [2:0] TS_INT0 = 3'h0;
  localparam logic [2:0] TS_CH1ED = 3'h4;
  localparam logic [2:0] TS_CH1 = 3'h5;
  localparam logic [2:0] TS_CH2 = 3'h6;
  localparam logic [2:0] TS_EXT = 3'h7;
  // Master mode codes
  localparam logic [2:0] MMS_ENABLE = 3'h1;
  localparam logic [2:0] MMS_UPDATE = 3'h2;
  // Capture source codes: own pin, other channel's pin
  localparam logic [1:0] CCS_OWN = 2'h1;
  localparam logic [1:0] CCS_OTHER = 2'h2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: design/tss_input_cond.sv
// Input conditioner: resynchroniser, digital filter and polarity select for one input
`timescale 1ns/1ns
`default_nettype none
module tss_input_cond #(
  parameter int FW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic [FW-1:0] filt,
  input wire logic invert,
  output logic level
);
  logic syncA_q, syncB_q, out_q;
  logic [FW-1:0] cnt_q;

  // Two-flop resynchroniser; only the second flop is looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end else begin
      syncA_q <= pin;
      syncB_q <= syncA_q;
    end
  end

  // A new level must persist filt extra samples; zero passes it at once
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (syncB_q == out_q) begin
      cnt_q <= '0;
    end else if (cnt_q >= filt) begin
      cnt_q <= '0;
      out_q <= syncB_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Polarity 0: rising edge / high level active
  assign level = out_q ^ invert;
endmodule
`default_nettype wire

// file: design/tss_slave_ctrl.sv
// Timer slave-mode controller, trigger path and master trigger output with AXI4-Lite registers
//
// Summary of operation
// - XOR select feeds channel 1 from pins 2-4
// - XOR signal serves every channel 1 function
// - Reset mode clears counter, prescaler, maybe update
// - Reset trigger sets flag; enable gates request
// - Trigger select picks internal, ch1 or ch2
// - Gated mode counts only when gate and enable
// - Gated mode flags start and stop
// - Trigger mode edge sets enable and flag
// - Pin trigger inputs resynchronised to timer clock; internal trigger zero is not
// - External clock 2 combines with reset/gated/trigger
// - External trigger filter, prescale, polarity, enable
// - External clock 2 plus trigger counts external edges
// - Capture select 01 routes own pin, polarity
// - Master mode 010 pulses output on update
// - External clock 1 counts selected trigger edges
// - Master mode 1xx drives compare output out
// - Trigger link resets, starts, stops, clocks other
// - Internal trigger zero is other timer's output
// - Master mode 001 presents enable bit, not gated counter enable
`timescale 1ns/1ns
`default_nettype none
module tss_slave_ctrl #(
  parameter int CW = 16,
  parameter int FW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ch1Pin,
  input wire logic ch2Pin,
  input wire logic ch3Pin,
  input wire logic ch4Pin,
  input wire logic extTrigPin,
  input wire logic internalTriggerZero,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic triggerOutput,
  output logic compareOutput,
  output logic trigIrq
);
  logic [7:0] ctrl_q;
  logic [15:0] smc_q, cap_q;
  logic [CW-1:0] arr_q, cmp_q, psc_q, cnt_q, pscCnt_q, arrSh_q, cmpSh_q;
  logic tif_q, selPrev_q, ch1Prev_q, gatePrev_q, extPrev_q, trigOut_q, irq_q, ocRef_q;
  logic [2:0] extDiv_q;
  logic [7:0] awAddr_q, arAddr_q;
  logic awHeld_q, wHeld_q, bvalid_q, bresp_q, rvalid_q, rresp_q;
  logic [31:0] wData_q, rdata_q;
  logic [3:0] wStrb_q;

  // Field views of the control registers
  wire cen = ctrl_q[tss_pkg::CTRL_CEN];
  wire urs = ctrl_q[tss_pkg::CTRL_URS];
  wire xorSel = ctrl_q[tss_pkg::CTRL_XOR];
  wire tie = ctrl_q[tss_pkg::CTRL_TIE];
  wire [2:0] mms = ctrl_q[tss_pkg::CTRL_MMS +: 3];
  wire [2:0] sms = smc_q[tss_pkg::SMC_SMS +: 3];
  wire [2:0] tsel = smc_q[tss_pkg::SMC_TS +: 3];
  wire [1:0] etps = smc_q[tss_pkg::SMC_ETPS +: 2];
  wire ece = smc_q[tss_pkg::SMC_ECE];
  wire [1:0] cc1s = cap_q[tss_pkg::CAP_CC1S +: 2];
  wire [1:0] cc2s = cap_q[tss_pkg::CAP_CC2S +: 2];

  // Channel 1 raw input; the XOR result replaces the pin everywhere
  wire ch1Raw = xorSel ? (ch2Pin ^ ch3Pin ^ ch4Pin) : ch1Pin;
  // Capture source selection per channel
  wire ch1Src = (cc1s == tss_pkg::CCS_OWN) ? ch1Raw :
                (cc1s == tss_pkg::CCS_OTHER) ? ch2Pin : 1'b0;
  wire ch2Src = (cc2s == tss_pkg::CCS_OWN) ? ch2Pin :
                (cc2s == tss_pkg::CCS_OTHER) ? ch1Raw : 1'b0;

  // Conditioner inputs: 0 channel 1, 1 channel 2, 2 external trigger
  wire [2:0] condPin = {extTrigPin, ch2Src, ch1Src};
  wire [FW-1:0] condFilt [3];
  wire [2:0] condInv = {smc_q[tss_pkg::SMC_ETP], cap_q[tss_pkg::CAP_CC2P],
                        cap_q[tss_pkg::CAP_CC1P]};
  wire [2:0] condLvl;
  assign condFilt[0] = cap_q[tss_pkg::CAP_IC1F +: FW];
  assign condFilt[1] = cap_q[tss_pkg::CAP_IC2F +: FW];
  assign condFilt[2] = smc_q[tss_pkg::SMC_ETF +: FW];

  // Each pin input is resynchronised before the slave logic sees it; internal trigger zero is not
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gCond
      tss_input_cond #(.FW(FW)) uCond (
        .clk(clk),
        .rst(rst),
        .pin(condPin[gi]),
        .filt(condFilt[gi]),
        .invert(condInv[gi]),
        .level(condLvl[gi])
      );
    end
  endgenerate

  wire ti1fp1 = condLvl[0];
  wire ti2fp2 = condLvl[1];
  wire extLvl = condLvl[2];

  // External trigger edge and power-of-two prescaler
  wire extRise = extLvl & ~extPrev_q;
  wire [2:0] extMask = 3'(3'h1 << etps) - 3'h1;
  wire extTick = extRise & ((extDiv_q & extMask) == extMask);

  // Trigger selection; external trigger as source is legal but discouraged
  wire selTrig = (tsel == tss_pkg::TS_INT0) ? internalTriggerZero :
                 (tsel == tss_pkg::TS_CH1ED) ? (ti1fp1 ^ ch1Prev_q) :
                 (tsel == tss_pkg::TS_CH1) ? ti1fp1 :
                 (tsel == tss_pkg::TS_CH2) ? ti2fp2 :
                 (tsel == tss_pkg::TS_EXT) ? extLvl : 1'b0;
  wire trgRise = selTrig & ~selPrev_q;

  // Mode decode; clock mode 2 only joins off/reset/gated/trigger modes
  wire modeReset = sms == tss_pkg::SMS_RESET;
  wire modeGated = sms == tss_pkg::SMS_GATED;
  wire modeTrig = sms == tss_pkg::SMS_TRIG;
  wire modeExt1 = sms == tss_pkg::SMS_EXT1;
  wire ecm2 = ece & (sms == tss_pkg::SMS_OFF | modeReset | modeGated | modeTrig);
  wire gateOn = cen & selTrig;
  wire countEn = modeGated ? gateOn : cen;
  wire baseTick = ecm2 ? extTick : (modeExt1 ? trgRise : 1'b1);
  wire pscDone = countEn & baseTick & (pscCnt_q == psc_q);
  wire ovf = pscDone & (cnt_q == arrSh_q);
  wire rstTrig = modeReset & trgRise;
  wire updateEv = ovf | (rstTrig & ~urs);
  wire trigSet = rstTrig | (modeTrig & trgRise) |
                 (modeGated & (gateOn != gatePrev_q));

  // AXI write decode: address and data may arrive in either order
  wire wrGo = awHeld_q & wHeld_q & ~bvalid_q;
  wire [31:0] wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  wire wrCtrl = wrGo & (awAddr_q == tss_pkg::OFS_CTRL);
  wire wrSmc = wrGo & (awAddr_q == tss_pkg::OFS_SMC);
  wire wrCap = wrGo & (awAddr_q == tss_pkg::OFS_CAP);
  wire wrArr = wrGo & (awAddr_q == tss_pkg::OFS_ARR);
  wire wrCmp = wrGo & (awAddr_q == tss_pkg::OFS_CMP);
  wire wrCnt = wrGo & (awAddr_q == tss_pkg::OFS_CNT);
  wire wrStat = wrGo & (awAddr_q == tss_pkg::OFS_STAT);
  wire wrPsc = wrGo & (awAddr_q == tss_pkg::OFS_PSC);
  wire wrHit = wrCtrl | wrSmc | wrCap | wrArr | wrCmp | wrCnt | wrStat | wrPsc;
  wire [31:0] mw = wData_q & wMask;
  wire [7:0] ctrlNew = (ctrl_q & ~wMask[7:0]) | mw[7:0];
  wire [15:0] smcNew = (smc_q & ~wMask[15:0]) | mw[15:0];
  wire [15:0] capNew = (cap_q & ~wMask[15:0]) | mw[15:0];
  wire [CW-1:0] cwNew = mw[CW-1:0];
  wire [CW-1:0] cwKeep = ~wMask[CW-1:0];
  wire tifClr = wrStat & mw[tss_pkg::STAT_TIF];

  // AXI read decode; unmapped addresses answer SLVERR with zero data
  wire rdGo = s_axi_arvalid & ~s_axi_arready & ~rvalid_q;
  wire rdHit = (s_axi_araddr[7:5] == 3'h0) & (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] rdMux =
    (s_axi_araddr == tss_pkg::OFS_CTRL) ? {24'h0, ctrl_q} :
    (s_axi_araddr == tss_pkg::OFS_SMC) ? {16'h0, smc_q} :
    (s_axi_araddr == tss_pkg::OFS_CAP) ? {16'h0, cap_q} :
    (s_axi_araddr == tss_pkg::OFS_ARR) ? 32'(arr_q) :
    (s_axi_araddr == tss_pkg::OFS_CMP) ? 32'(cmp_q) :
    (s_axi_araddr == tss_pkg::OFS_CNT) ? 32'(cnt_q) :
    (s_axi_araddr == tss_pkg::OFS_STAT) ? {31'h0, tif_q} :
    (s_axi_araddr == tss_pkg::OFS_PSC) ? 32'(psc_q) : 32'h0;

  // Address and data capture, one outstanding write
  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (wrGo) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (wrGo) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // Handshake outputs held in flops; ready drops while a word is held
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 1'b0;
      s_axi_arready <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      s_axi_awready <= ~awHeld_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~wHeld_q & ~(s_axi_wvalid & s_axi_wready);
      if (wrGo) begin
        bvalid_q <= 1'b1;
        bresp_q <= ~wrHit;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      s_axi_arready <= rdGo;
      if (rdGo) begin
        rvalid_q <= 1'b1;
        rresp_q <= ~rdHit;
        rdata_q <= rdHit ? rdMux : 32'h0;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q ? tss_pkg::RESP_SLVERR : tss_pkg::RESP_OKAY;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q ? tss_pkg::RESP_SLVERR : tss_pkg::RESP_OKAY;
  assign s_axi_rdata = rdata_q;

  // Configuration; a trigger start beats a same-cycle software clear of enable
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= tss_pkg::CTRL_RST;
      smc_q <= tss_pkg::SMC_RST;
      cap_q <= tss_pkg::CAP_RST;
      arr_q <= CW'(tss_pkg::ARR_RST);
      cmp_q <= '0;
      psc_q <= '0;
    end else begin
      if (wrCtrl) ctrl_q <= ctrlNew;
      if (modeTrig & trgRise) ctrl_q[tss_pkg::CTRL_CEN] <= 1'b1;
      if (wrSmc) smc_q <= smcNew;
      if (wrCap) cap_q <= capNew;
      if (wrArr) arr_q <= (arr_q & cwKeep) | cwNew;
      if (wrCmp) cmp_q <= (cmp_q & cwKeep) | cwNew;
      if (wrPsc) psc_q <= (psc_q & cwKeep) | cwNew;
    end
  end

  // Counter and prescaler; reset trigger wins over counting
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      pscCnt_q <= '0;
    end else if (rstTrig) begin
      cnt_q <= '0;
      pscCnt_q <= '0;
    end else if (wrCnt) begin
      cnt_q <= (cnt_q & cwKeep) | cwNew;
    end else if (countEn & baseTick) begin
      pscCnt_q <= pscDone ? '0 : pscCnt_q + 1'b1;
      if (pscDone) cnt_q <= ovf ? '0 : cnt_q + 1'b1;
    end
  end

  // Buffered reload and compare values take effect only on update
  always_ff @(posedge clk) begin
    if (rst) begin
      arrSh_q <= CW'(tss_pkg::ARR_RST);
      cmpSh_q <= '0;
    end else if (updateEv) begin
      arrSh_q <= arr_q;
      cmpSh_q <= cmp_q;
    end
  end

  // Edge history, trigger flag (set beats clear) and outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      selPrev_q <= 1'b0;
      ch1Prev_q <= 1'b0;
      gatePrev_q <= 1'b0;
      extPrev_q <= 1'b0;
      extDiv_q <= 3'h0;
      tif_q <= 1'b0;
      irq_q <= 1'b0;
      trigOut_q <= 1'b0;
      ocRef_q <= 1'b0;
    end else begin
      selPrev_q <= selTrig;
      ch1Prev_q <= ti1fp1;
      gatePrev_q <= gateOn;
      extPrev_q <= extLvl;
      if (extRise) extDiv_q <= extDiv_q + 3'h1;
      tif_q <= trigSet | (tif_q & ~tifClr);
      irq_q <= tie & (trigSet | (tif_q & ~tifClr));
      ocRef_q <= cnt_q < cmpSh_q;
      // Master output: enable level, update pulse or compare reference
      trigOut_q <= (mms == tss_pkg::MMS_ENABLE) ? cen :
                   (mms == tss_pkg::MMS_UPDATE) ? updateEv :
                   mms[2] ? (cnt_q < cmpSh_q) : 1'b0;
    end
  end

  assign triggerOutput = trigOut_q;
  assign compareOutput = ocRef_q;
  assign trigIrq = irq_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_xor_feed: assert property (xorSel && cc1s == tss_pkg::CCS_OWN |-> ch1Src == (ch2Pin ^ ch3Pin ^ ch4Pin))
    else $error("xor select does not feed channel 1");
  a_trig_select: assert property (tsel == tss_pkg::TS_CH2 |-> selTrig == ti2fp2)
    else $error("trigger select mismatch");
  a_reset_clear: assert property (rstTrig |=> cnt_q == '0 && pscCnt_q == '0)
    else $error("reset trigger did not clear counter");
  a_irq_gate: assert property (trigSet && !tie |=> !trigIrq)
    else $error("request raised while disabled");
  a_flag_set: assert property (trigSet |=> tif_q)
    else $error("trigger flag not set");
  a_gate_hold: assert property (modeGated && !cen && !wrCnt |=> $stable(cnt_q))
    else $error("counted while gated off");
  a_trig_start: assert property (modeTrig && trgRise |=> cen ##0 tif_q)
    else $error("trigger edge did not start counter");
  a_update_out: assert property (mms == tss_pkg::MMS_UPDATE && updateEv |=> triggerOutput)
    else $error("no output pulse on update");
  a_enable_out: assert property (mms == tss_pkg::MMS_ENABLE |=> triggerOutput == $past(cen))
    else $error("enable not presented on output");
  a_idle_hold: assert property (sms == tss_pkg::SMS_OFF && !ece && !cen && !wrCnt
                                |=> $stable(cnt_q))
    else $error("counter moved while disabled");

  c_reset_mode: cover property (rstTrig ##1 cnt_q == '0);
  c_gated_run: cover property (modeGated && gateOn [*3]);
  c_ext2_trig: cover property (ecm2 && modeTrig && trgRise ##[1:20] extTick);
endmodule
`default_nettype wire

// file: testbench/tss_partner.sv
// Far-side model: channel pins, external trigger pin and companion timer trigger
`timescale 1ns/1ns
`default_nettype none
module tss_partner (
  input wire logic clk,
  output logic [3:0] chPins,
  output logic extTrig,
  output logic itrOut
);
  // All lines idle low until a scenario moves them
  initial begin
    chPins = 4'h0;
    extTrig = 1'b0;
    itrOut = 1'b0;
  end
  // Pin level change, launched just after an edge
  task automatic setPin(input int i, input logic v);
    @(posedge clk);
    chPins[i] <= v;
  endtask
  // Pulses of three cycles high and four low between pulses, so no edge is lost in the resynchroniser
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge clk);
      if (sel == 0) begin
        itrOut <= 1'b1;
      end else begin
        extTrig <= 1'b1;
      end
      repeat (3) @(posedge clk);
      itrOut <= 1'b0;
      extTrig <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_timer_slave_mode_sync.sv
// Self-checking bench for the timer slave-mode block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin nTests++; if ((s) !== (e)) begin badCount++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_timer_slave_mode_sync;
  logic clk, rst, trgOut, cmpOut, irq, extTrig, itr;
  logic [3:0] chPins;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int badCount, nTests, cycles, seed, trgPulses, v, n, a;
  logic [7:0] rOfs[4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
  logic [31:0] rVal[4] = '{32'h0, 32'h0, 32'h0, 32'hffff};
  int itrEdges;
  logic itrPrev;

  tss_slave_ctrl dut (.clk(clk), .rst(rst), .ch1Pin(chPins[0]), .ch2Pin(chPins[1]),
    .ch3Pin(chPins[2]), .ch4Pin(chPins[3]), .extTrigPin(extTrig),
    .internalTriggerZero(itr), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .triggerOutput(trgOut), .compareOutput(cmpOut), .trigIrq(irq));
  tss_partner far (.clk(clk), .chPins(chPins), .extTrig(extTrig), .itrOut(itr));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Model of clock mode 1: each rising companion edge is one count
  always @(posedge clk) begin
    itrPrev <= itr;
    if (itr === 1'b1 && itrPrev !== 1'b1) itrEdges++;
  end
  // Hang guard and update-pulse counter; a pulse held two cycles counts twice
  always @(posedge clk) begin
    cycles++;
    if (trgOut === 1'b1) trgPulses++;
    if (cycles == 20000) begin
      badCount++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic doReset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] ad);
    @(posedge clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic endTest(input string s);
    $display("Test %s finished", s);
  endtask

  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    seed = 10;
    doReset();
    // Reset values from a table, then unmapped places refused
    foreach (rOfs[i]) begin
      rdr(rOfs[i]);
      `CHK("reset value", rVal[i], rd)
    end
    rdr(8'h20);
    `CHK("unmapped rresp", tss_pkg::RESP_SLVERR, resp)
    wr(8'h24, 32'h1);
    `CHK("unmapped bresp", tss_pkg::RESP_SLVERR, resp)
    endTest("registers");
    // Chained clocking: counter must advance by exactly the pulse count
    v = ($random(seed) & 32'h7fff) | 32'h1000;
    n = ($random(seed) & 7) + 1;
    wr(tss_pkg::OFS_CNT, v);
    wr(tss_pkg::OFS_SMC, 32'h7);
    wr(tss_pkg::OFS_CTRL, 32'h1);
    a = itrEdges;
    far.pulse(0, n);
    repeat (6) @(posedge clk);
    rdr(tss_pkg::OFS_CNT);
    `CHK("ext clock 1 count", 32'(v + itrEdges - a), rd)
    endTest("external clock 1");
    // Start from the companion trigger, enable shown on the trigger output
    doReset();
    wr(tss_pkg::OFS_SMC, 32'h6);
    wr(tss_pkg::OFS_CTRL, 32'h10);
    `CHK("trgout before", 1'b0, trgOut)
    far.pulse(0, 1);
    repeat (4) @(posedge clk);
    rdr(tss_pkg::OFS_CTRL);
    `CHK("cen set", 1'b1, rd[0])
    `CHK("trgout enable", 1'b1, trgOut)
    rdr(tss_pkg::OFS_STAT);
    `CHK("trig flag", 1'b1, rd[0])
    endTest("trigger mode");
    // Reset mode: update pulse only with the source bit low, irq only when enabled
    for (int u = 0; u < 2; u++) begin
      doReset();
      far.setPin(0, 1'b0);
      wr(tss_pkg::OFS_CNT, v);
      wr(tss_pkg::OFS_CAP, 32'h1);
      wr(tss_pkg::OFS_CMP, 32'h400);
      wr(tss_pkg::OFS_SMC, 32'h54);
      wr(tss_pkg::OFS_CTRL, 32'h21 | (u << 1) | ((1 - u) << 3));
      trgPulses = 0;
      far.setPin(0, 1'b1);
      repeat (10) @(posedge clk);
      rdr(tss_pkg::OFS_CNT);
      `CHK("cnt cleared", 1'b1, rd < 32'd20)
      `CHK("update pulses", 1 - u, trgPulses)
      rdr(tss_pkg::OFS_STAT);
      `CHK("reset flag", 1'b1, rd[0])
      `CHK("irq", 1'(1 - u), irq)
      wr(tss_pkg::OFS_STAT, 32'h1);
      repeat (2) @(posedge clk);
      `CHK("irq cleared", 1'b0, irq)
      // Compare shadow loads only through the update; master mode 100 shows it
      wr(tss_pkg::OFS_CTRL, 32'h41);
      repeat (2) @(posedge clk);
      `CHK("compare out", 1'(1 - u), cmpOut)
      `CHK("compare trgout", 1'(1 - u), trgOut)
    end
    endTest("reset mode");
    // Gated by channel 2: stands while closed, runs while open, flags both changes
    doReset();
    far.setPin(0, 1'b0);
    wr(tss_pkg::OFS_CAP, 32'h100);
    wr(tss_pkg::OFS_SMC, 32'h65);
    wr(tss_pkg::OFS_CTRL, 32'h1);
    for (int g = 0; g < 3; g++) begin
      if (g > 0) far.setPin(1, 1'(g & 1));
      repeat (8) @(posedge clk);
      rdr(tss_pkg::OFS_CNT);
      a = rd;
      rdr(tss_pkg::OFS_CNT);
      `CHK("gate count", 1'(g & 1), 1'(rd != a))
      rdr(tss_pkg::OFS_STAT);
      `CHK("gate flag", 1'(g > 0), rd[0])
      wr(tss_pkg::OFS_STAT, 32'h1);
    end
    endTest("gated mode");
    // Clock mode 2 with trigger: no counting before the start edge
    doReset();
    wr(tss_pkg::OFS_CNT, v);
    wr(tss_pkg::OFS_CAP, 32'h1);
    wr(tss_pkg::OFS_SMC, 32'h8056);
    far.pulse(1, 2);
    far.setPin(0, 1'b1);
    repeat (8) @(posedge clk);
    rdr(tss_pkg::OFS_CTRL);
    `CHK("ece start", 1'b1, rd[0])
    far.pulse(1, n);
    repeat (6) @(posedge clk);
    rdr(tss_pkg::OFS_CNT);
    `CHK("ext clock 2 count", 32'(v + n), rd)
    endTest("external clock 2");
    // XOR of pins 2-4 replaces the channel 1 pin as trigger
    doReset();
    far.setPin(0, 1'b0);
    wr(tss_pkg::OFS_CAP, 32'h1);
    wr(tss_pkg::OFS_SMC, 32'h56);
    wr(tss_pkg::OFS_CTRL, 32'h4);
    far.setPin(0, 1'b1);
    repeat (8) @(posedge clk);
    rdr(tss_pkg::OFS_CTRL);
    `CHK("ch1 pin ignored", 1'b0, rd[0])
    far.setPin(2, 1'b1);
    repeat (8) @(posedge clk);
    rdr(tss_pkg::OFS_CTRL);
    `CHK("xor start", 1'b1, rd[0])
    endTest("xor input");
    give_verdict();
  end
endmodule
`default_nettype wire
